// File: logic/bsfe_pkg.sv
package bsfe_pkg;

  // Execution operation codes presented by the instruction decoder
  typedef enum logic [3:0] {
    OP_NOP                    = 4'h0,
    OP_IO_BIT_SET_OP          = 4'h1,
    OP_IO_BIT_CLEAR_OP        = 4'h2,
    OP_SHIFT_LEFT_LOGICAL_OP  = 4'h3,
    OP_SHIFT_RIGHT_LOGICAL_OP = 4'h4,
    OP_ROTATE_LEFT_CARRY_OP   = 4'h5,
    OP_ROTATE_RIGHT_CARRY_OP  = 4'h6,
    OP_SHIFT_RIGHT_ARITH_OP   = 4'h7,
    OP_NIBBLE_SWAP_OP         = 4'h8,
    OP_FLAG_SET_BY_INDEX_OP   = 4'h9,
    OP_FLAG_CLEAR_BY_INDEX_OP = 4'ha,
    OP_BIT_TO_TRANSFER_OP     = 4'hb,
    OP_TRANSFER_TO_BIT_OP     = 4'hc,
    OP_SLEEP_OP               = 4'hd,
    OP_WATCHDOG_RESTART_OP    = 4'he
  } bsfe_op_e;

  // Status register bit positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Register map, byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_OPCOUNT = 4'hc;

  // Reset values and field layout
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [1:0] SLEEP_MODE_RST = 2'h0;
  localparam int SLEEP_MODE_LSB = 0;
  localparam int SLEEP_MODE_W = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Issue slots per operation
  localparam int IO_BIT_CYCLES = 2;
  localparam int SIMPLE_OP_CYCLES = 1;

endpackage

// File: logic/bsfe_shift_unit.sv
`timescale 1ns/1ps
module bsfe_shift_unit
  import bsfe_pkg::*;
(
  // Operation
  input wire bsfe_op_e i_op,
  input wire logic [7:0] i_data,
  input wire logic i_carry,
  // Result and flags
  output logic [7:0] o_result,
  output logic o_c,
  output logic o_z,
  output logic o_n,
  output logic o_v
);

  always_comb begin
    o_result = i_data;
    o_c = i_carry;
    unique case (i_op)
      OP_SHIFT_LEFT_LOGICAL_OP: begin
        o_result = {i_data[6:0], 1'b0};
        o_c = i_data[7];
      end
      OP_SHIFT_RIGHT_LOGICAL_OP: begin
        o_result = {1'b0, i_data[7:1]};
        o_c = i_data[0];
      end
      OP_ROTATE_LEFT_CARRY_OP: begin
        o_result = {i_data[6:0], i_carry};
        o_c = i_data[7];
      end
      OP_ROTATE_RIGHT_CARRY_OP: begin
        o_result = {i_carry, i_data[7:1]};
        o_c = i_data[0];
      end
      OP_SHIFT_RIGHT_ARITH_OP: begin
        o_result = {i_data[7], i_data[7:1]};
        o_c = i_data[0];
      end
      OP_NIBBLE_SWAP_OP: begin
        o_result = {i_data[3:0], i_data[7:4]};
      end
      default: begin
        o_result = i_data;
      end
    endcase
    o_z = (o_result == 8'h00);
    o_n = o_result[7];
    // Overflow of a shift is sign change against carry out
    o_v = o_result[7] ^ o_c;
  end

endmodule

// File: logic/bsfe_exec_unit.sv
`timescale 1ns/1ps
module bsfe_exec_unit
  import bsfe_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Decoder issue port
  input wire logic i_op_valid,
  input wire bsfe_op_e i_op,
  input wire logic [2:0] i_op_bit,
  input wire logic [5:0] i_op_io_addr,
  input wire logic [7:0] i_op_data,
  output logic o_op_ready,
  // Register file write-back
  output logic o_rd_we,
  output logic [7:0] o_rd_data,
  // I/O space
  output logic o_io_re,
  output logic [5:0] o_io_addr,
  input wire logic [7:0] i_io_rdata,
  output logic o_io_we,
  output logic [7:0] o_io_wdata,
  // Status and system requests
  output logic [7:0] o_status_register,
  output logic o_sleep_req,
  output logic [1:0] o_sleep_mode,
  output logic o_wdr_req,
  // AXI4-Lite slave
  input wire logic i_s_axi_awvalid,
  input wire logic [3:0] i_s_axi_awaddr,
  output logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_wready,
  output logic o_s_axi_bvalid,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic [3:0] i_s_axi_araddr,
  output logic o_s_axi_arready,
  output logic o_s_axi_rvalid,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_s_axi_rready
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_IO_RD = 3'b010,
    ST_IO_WR = 3'b100
  } bsfe_state_e;

  typedef struct packed {
    bsfe_state_e state;
    logic [7:0] status_register;
    logic rd_we;
    logic [7:0] rd_data;
    logic [5:0] io_addr;
    logic [2:0] io_bit;
    logic io_set;
    logic io_we;
    logic [7:0] io_wdata;
    logic sleep_req;
    logic wdr_req;
    logic [1:0] sleep_mode;
    logic [7:0] last_result;
    logic [15:0] op_count;
    logic aw_held;
    logic [3:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bsfe_state_s;

  bsfe_state_s r;
  bsfe_state_s n;

  logic [7:0] sh_result;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic take;

  // True for every word address that holds a register
  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == ADDR_STATUS) || (a == ADDR_CTRL) ||
                  (a == ADDR_RESULT) || (a == ADDR_OPCOUNT);
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = 8'h01 << b;
  endfunction

  bsfe_shift_unit u_shift (
    .i_op(i_op),
    .i_data(i_op_data),
    .i_carry(r.status_register[FLAG_C]),
    .o_result(sh_result),
    .o_c(sh_c),
    .o_z(sh_z),
    .o_n(sh_n),
    .o_v(sh_v)
  );

  // Second slot of an I/O bit op blocks issue while the read is out
  assign o_op_ready = (r.state != ST_IO_RD);
  assign take = i_op_valid && o_op_ready;

  always_comb begin
    n = r;
    n.rd_we = 1'b0;
    n.io_we = 1'b0;
    n.sleep_req = 1'b0;
    n.wdr_req = 1'b0;

    // Software side: write address and data taken in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      n.aw_held = 1'b1;
      n.awaddr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      n.w_held = 1'b1;
      n.wdata = i_s_axi_wdata;
      n.wstrb = i_s_axi_wstrb;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = addr_mapped(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (r.wstrb[0]) begin
        if (r.awaddr == ADDR_STATUS) begin
          n.status_register = r.wdata[7:0];
        end else if (r.awaddr == ADDR_CTRL) begin
          n.sleep_mode = r.wdata[SLEEP_MODE_LSB +: SLEEP_MODE_W];
        end
      end
    end
    if (r.bvalid && i_s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    if (i_s_axi_arvalid && o_s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = addr_mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (i_s_axi_araddr)
        ADDR_STATUS: n.rdata = {24'h000000, r.status_register};
        ADDR_CTRL: n.rdata = {30'h0, r.sleep_mode};
        ADDR_RESULT: n.rdata = {24'h000000, r.last_result};
        ADDR_OPCOUNT: n.rdata = {16'h0000, r.op_count};
        default: n.rdata = 32'h00000000;
      endcase
    end else if (r.rvalid && i_s_axi_rready) begin
      n.rvalid = 1'b0;
    end

    // I/O read-modify-write sequence
    unique case (r.state)
      ST_IDLE: begin
        n.state = ST_IDLE;
      end
      ST_IO_RD: begin
        // Only the selected bit changes, the rest is written back as read
        if (r.io_set) begin
          n.io_wdata = i_io_rdata | bit_mask(r.io_bit);
        end else begin
          n.io_wdata = i_io_rdata & ~bit_mask(r.io_bit);
        end
        n.io_we = 1'b1;
        n.state = ST_IO_WR;
      end
      ST_IO_WR: begin
        n.state = ST_IDLE;
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase

    // Instruction issue; flag updates here override a software write
    if (take) begin
      n.op_count = r.op_count + 16'h0001;
      unique case (i_op)
        OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP: begin
          n.io_addr = i_op_io_addr;
          n.io_bit = i_op_bit;
          n.io_set = (i_op == OP_IO_BIT_SET_OP);
          n.state = ST_IO_RD;
        end
        OP_SHIFT_LEFT_LOGICAL_OP, OP_SHIFT_RIGHT_LOGICAL_OP,
        OP_SHIFT_RIGHT_ARITH_OP: begin
          n.rd_we = 1'b1;
          n.rd_data = sh_result;
          n.last_result = sh_result;
          n.status_register[FLAG_C] = sh_c;
          n.status_register[FLAG_Z] = sh_z;
          n.status_register[FLAG_N] = sh_n;
          n.status_register[FLAG_V] = sh_v;
        end
        OP_ROTATE_LEFT_CARRY_OP, OP_ROTATE_RIGHT_CARRY_OP: begin
          n.rd_we = 1'b1;
          n.rd_data = sh_result;
          n.last_result = sh_result;
          n.status_register[FLAG_C] = sh_c;
          n.status_register[FLAG_Z] = sh_z;
          n.status_register[FLAG_N] = sh_n;
          n.status_register[FLAG_V] = sh_v;
        end
        OP_NIBBLE_SWAP_OP: begin
          n.rd_we = 1'b1;
          n.rd_data = sh_result;
          n.last_result = sh_result;
        end
        OP_FLAG_SET_BY_INDEX_OP: begin
          n.status_register[i_op_bit] = 1'b1;
        end
        OP_FLAG_CLEAR_BY_INDEX_OP: begin
          n.status_register[i_op_bit] = 1'b0;
        end
        OP_BIT_TO_TRANSFER_OP: begin
          n.status_register[FLAG_T] = i_op_data[i_op_bit];
        end
        OP_TRANSFER_TO_BIT_OP: begin
          n.rd_we = 1'b1;
          n.rd_data = (i_op_data & ~bit_mask(i_op_bit)) |
                      ({8{r.status_register[FLAG_T]}} & bit_mask(i_op_bit));
          n.last_result = n.rd_data;
        end
        OP_SLEEP_OP: begin
          n.sleep_req = 1'b1;
        end
        OP_WATCHDOG_RESTART_OP: begin
          n.wdr_req = 1'b1;
        end
        OP_NOP: begin
          n.rd_we = 1'b0;
        end
        default: begin
          n.rd_we = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '{
        state: ST_IDLE,
        status_register: STATUS_RST,
        rd_we: 1'b0,
        rd_data: 8'h00,
        io_addr: 6'h00,
        io_bit: 3'h0,
        io_set: 1'b0,
        io_we: 1'b0,
        io_wdata: 8'h00,
        sleep_req: 1'b0,
        wdr_req: 1'b0,
        sleep_mode: SLEEP_MODE_RST,
        last_result: 8'h00,
        op_count: 16'h0000,
        aw_held: 1'b0,
        awaddr: 4'h0,
        w_held: 1'b0,
        wdata: 32'h00000000,
        wstrb: 4'h0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        rvalid: 1'b0,
        rdata: 32'h00000000,
        rresp: RESP_OKAY
      };
    end else begin
      r <= n;
    end
  end

  assign o_rd_we = r.rd_we;
  assign o_rd_data = r.rd_data;
  assign o_io_re = (r.state == ST_IO_RD);
  assign o_io_addr = r.io_addr;
  assign o_io_we = r.io_we;
  assign o_io_wdata = r.io_wdata;
  assign o_status_register = r.status_register;
  assign o_sleep_req = r.sleep_req;
  assign o_sleep_mode = r.sleep_mode;
  assign o_wdr_req = r.wdr_req;

  // One write in flight; the holding slots stall further beats
  assign o_s_axi_awready = !r.aw_held && !r.bvalid;
  assign o_s_axi_wready = !r.w_held && !r.bvalid;
  assign o_s_axi_bvalid = r.bvalid;
  assign o_s_axi_bresp = r.bresp;
  assign o_s_axi_arready = !r.rvalid;
  assign o_s_axi_rvalid = r.rvalid;
  assign o_s_axi_rdata = r.rdata;
  assign o_s_axi_rresp = r.rresp;

endmodule

// File: dv/bsfe_exec_unit_assertions.sv
`timescale 1ns/1ps
module bsfe_exec_unit_assertions
  import bsfe_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_op_valid,
  input wire bsfe_op_e i_op,
  input wire logic [2:0] i_op_bit,
  input wire logic [7:0] i_op_data,
  input wire logic o_op_ready,
  input wire logic o_rd_we,
  input wire logic [7:0] o_rd_data,
  input wire logic o_io_re,
  input wire logic [7:0] i_io_rdata,
  input wire logic o_io_we,
  input wire logic [7:0] o_io_wdata,
  input wire logic [7:0] o_status_register,
  input wire logic o_sleep_req,
  input wire logic o_wdr_req
);
  logic [7:0] d_r;
  logic [2:0] b_r;
  logic [15:0] take;
  // One-hot of the code taken at this edge
  assign take = (i_op_valid && o_op_ready) ? (16'h0001 << i_op) : 16'h0000;
  always_ff @(posedge i_clk) begin
    d_r <= i_op_data;
    b_r <= i_op_bit;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_io_set_seq: assert property (take[OP_IO_BIT_SET_OP] |=>
    (o_io_re && !o_op_ready) ##1 (o_io_we
    && o_io_wdata == ($past(i_io_rdata) | (8'h01 << $past(i_op_bit, 2)))))
    else $error("io set sequence wrong");
  chk_io_clr_seq: assert property (take[OP_IO_BIT_CLEAR_OP] |=>
    (o_io_re && !o_op_ready) ##1 (o_io_we
    && o_io_wdata == ($past(i_io_rdata) & ~(8'h01 << $past(i_op_bit, 2)))))
    else $error("io clear sequence wrong");
  chk_io_flags_kept: assert property ((take[1] || take[2]) |=>
    $stable(o_status_register) [*2]) else $error("io op moved flags");
  chk_shl_result: assert property (take[OP_SHIFT_LEFT_LOGICAL_OP] |=> o_rd_we
    && o_rd_data == {d_r[6:0], 1'b0} && o_status_register[0] == d_r[7])
    else $error("left shift wrong");
  chk_asr_result: assert property (take[OP_SHIFT_RIGHT_ARITH_OP] |=> o_rd_we
    && o_rd_data == {d_r[7], d_r[7:1]} && o_status_register[0] == d_r[0])
    else $error("arith shift wrong");
  chk_swap_halves: assert property (take[OP_NIBBLE_SWAP_OP] |=> o_rd_we
    && o_rd_data == {d_r[3:0], d_r[7:4]} && $stable(o_status_register))
    else $error("swap wrong");
  chk_flag_set: assert property (take[OP_FLAG_SET_BY_INDEX_OP] |=>
    o_status_register[b_r]) else $error("flag not set");
  chk_bit_store: assert property (take[OP_BIT_TO_TRANSFER_OP] |=>
    o_status_register[6] == d_r[b_r] && !o_rd_we) else $error("bit store wrong");
  chk_sleep_pulse: assert property (take[OP_SLEEP_OP] |=> o_sleep_req
    ##1 (!o_sleep_req || $past(take[OP_SLEEP_OP]))) else $error("sleep request not one pulse");
  chk_wdr_pulse: assert property (take[OP_WATCHDOG_RESTART_OP] |=> o_wdr_req
    ##1 (!o_wdr_req || $past(take[OP_WATCHDOG_RESTART_OP])))
    else $error("restart request not one pulse");
  chk_nop_quiet: assert property (take[OP_NOP] |=> !o_rd_we && !o_io_re
    && $stable(o_status_register)) else $error("idle op changed state");
  chk_lsr_result: assert property (take[OP_SHIFT_RIGHT_LOGICAL_OP] |=> o_rd_we
    && o_rd_data == {1'b0, d_r[7:1]} && o_status_register[0] == d_r[0])
    else $error("right shift wrong");
  chk_rol_result: assert property (take[OP_ROTATE_LEFT_CARRY_OP] |=> o_rd_we
    && o_rd_data == {d_r[6:0], $past(o_status_register[0])} && o_status_register[0] == d_r[7])
    else $error("left rotate wrong");
  chk_ror_result: assert property (take[OP_ROTATE_RIGHT_CARRY_OP] |=> o_rd_we
    && o_rd_data == {$past(o_status_register[0]), d_r[7:1]} && o_status_register[0] == d_r[0])
    else $error("right rotate wrong");
  chk_flag_clear: assert property (take[OP_FLAG_CLEAR_BY_INDEX_OP] |=>
    !o_status_register[b_r]) else $error("flag not cleared");
  chk_bit_load: assert property (take[OP_TRANSFER_TO_BIT_OP] |=> o_rd_we
    && o_rd_data[b_r] == $past(o_status_register[6])
    && (o_rd_data & ~(8'h01 << b_r)) == (d_r & ~(8'h01 << b_r))
    && $stable(o_status_register)) else $error("bit load wrong");
endmodule

bind bsfe_exec_unit bsfe_exec_unit_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_op_valid(i_op_valid), .i_op(i_op), .i_op_bit(i_op_bit), .i_op_data(i_op_data),
  .o_op_ready(o_op_ready), .o_rd_we(o_rd_we), .o_rd_data(o_rd_data), .o_io_re(o_io_re),
  .i_io_rdata(i_io_rdata), .o_io_we(o_io_we), .o_io_wdata(o_io_wdata),
  .o_status_register(o_status_register), .o_sleep_req(o_sleep_req), .o_wdr_req(o_wdr_req));

// File: dv/bsfe_io_model.sv
`timescale 1ns/1ps
module bsfe_io_model (
  input wire logic i_clk,
  input wire logic i_re,
  input wire logic i_we,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [64];
  logic [7:0] junk = 8'h5a;
  initial for (int i = 0; i < 64; i++) mem[i] = 8'(i * 37 + 5);
  always @(posedge i_clk) begin
    junk <= ~junk;
    if (i_we) mem[i_addr] <= i_wdata;
  end
  // Toggling junk outside a read so stale data never passes
  assign o_rdata = i_re ? mem[i_addr] : junk;
endmodule

// File: dv/bit_shift_flag_exec_unit_tb.sv
`timescale 1ns/1ps
module bit_shift_flag_exec_unit_tb;
  import bsfe_pkg::*;
  logic i_clk = 0, i_rst = 1, ov = 0, aw = 0, wv = 0, br = 0, ar = 0, rr = 0, tk = 0;
  bsfe_op_e op = OP_NOP;
  logic [2:0] ob = 0;
  logic [5:0] oa = 0, ioa;
  logic [7:0] od = 0, rdd, iwd, stat, iod, sr = 0, lrd = 0, iom [64];
  logic [3:0] awa = 0, ara = 0, ws = 0;
  logic [31:0] wd = 0, rdat;
  logic rdy, rwe, ire, iwe, slp, watchdog_restart_op, awr, wr, bv, arr, rv;
  logic [1:0] smode, bresp, rresp;
  logic [31:0] q [$];
  logic [31:0] ms, me;
  int mismatches = 0, samples_checked = 0, seed = 59280, cnt = 0;
  always #20 i_clk = ~i_clk;
  bsfe_exec_unit dut (.i_clk(i_clk), .i_rst(i_rst), .i_op_valid(ov), .i_op(op), .i_op_bit(ob),
    .i_op_io_addr(oa), .i_op_data(od), .o_op_ready(rdy), .o_rd_we(rwe), .o_rd_data(rdd),
    .o_io_re(ire), .o_io_addr(ioa), .i_io_rdata(iod), .o_io_we(iwe), .o_io_wdata(iwd),
    .o_status_register(stat), .o_sleep_req(slp), .o_sleep_mode(smode), .o_wdr_req(watchdog_restart_op),
    .i_s_axi_awvalid(aw), .i_s_axi_awaddr(awa), .o_s_axi_awready(awr), .i_s_axi_wvalid(wv),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .o_s_axi_wready(wr), .o_s_axi_bvalid(bv),
    .o_s_axi_bresp(bresp), .i_s_axi_bready(br), .i_s_axi_arvalid(ar), .i_s_axi_araddr(ara),
    .o_s_axi_arready(arr), .o_s_axi_rvalid(rv), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
    .i_s_axi_rready(rr));
  bsfe_io_model u_io (.i_clk(i_clk), .i_re(ire), .i_we(iwe), .i_addr(ioa), .i_wdata(iwd),
    .o_rdata(iod));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic limit(input int n);
    if (n >= 50) begin
      mismatches++;
      $display("mismatch at %0t: wait limit hit", $time);
      test_done;
    end
  endtask
  // Holds the op until it is taken, then predicts the result note
  task automatic issue(input bsfe_op_e o, input logic [2:0] b, input logic [5:0] a,
                       input logic [7:0] d);
    logic [7:0] r;
    logic c;
    logic we;
    int n;
    r = lrd;
    c = sr[0];
    n = 0;
    ov <= 1;
    op <= o;
    ob <= b;
    oa <= a;
    od <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (!rdy && n < 50);
    limit(n);
    cnt++;
    case (o)
      OP_SHIFT_LEFT_LOGICAL_OP: {c, r} = {d, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL_OP: {r, c} = {1'b0, d};
      OP_ROTATE_LEFT_CARRY_OP: {c, r} = {d, sr[0]};
      OP_ROTATE_RIGHT_CARRY_OP: {r, c} = {sr[0], d};
      OP_SHIFT_RIGHT_ARITH_OP: {r, c} = {d[7], d};
      OP_NIBBLE_SWAP_OP: r = {d[3:0], d[7:4]};
      OP_FLAG_SET_BY_INDEX_OP: sr[b] = 1'b1;
      OP_FLAG_CLEAR_BY_INDEX_OP: sr[b] = 1'b0;
      OP_BIT_TO_TRANSFER_OP: sr[6] = d[b];
      OP_TRANSFER_TO_BIT_OP: begin
        r = d;
        r[b] = sr[6];
      end
      OP_IO_BIT_SET_OP: iom[a][b] = 1'b1;
      OP_IO_BIT_CLEAR_OP: iom[a][b] = 1'b0;
      default: ;
    endcase
    if (o >= OP_SHIFT_LEFT_LOGICAL_OP && o <= OP_SHIFT_RIGHT_ARITH_OP)
      sr[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
    we = (o >= OP_SHIFT_LEFT_LOGICAL_OP && o <= OP_NIBBLE_SWAP_OP) || o == OP_TRANSFER_TO_BIT_OP;
    if (o == OP_IO_BIT_SET_OP || o == OP_IO_BIT_CLEAR_OP) q.push_back({9'h0, 1'b1, a, iom[a], sr});
    else q.push_back({13'h0, we, o == OP_WATCHDOG_RESTART_OP, o == OP_SLEEP_OP, r, sr});
    lrd = r;
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] rs = RESP_OKAY);
    int n;
    n = 0;
    aw <= 1;
    wv <= 1;
    awa <= a;
    wd <= d;
    ws <= s;
    br <= 1;
    do begin
      @(posedge i_clk);
      n++;
      if (aw && awr) aw <= 0;
      if (wv && wr) wv <= 0;
    end while (!bv && n < 50);
    limit(n);
    br <= 0;
    check(32'(bresp), 32'(rs));
    @(posedge i_clk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] e,
                     input logic [1:0] rs = RESP_OKAY);
    int n;
    n = 0;
    ar <= 1;
    ara <= a;
    rr <= 1;
    do begin
      @(posedge i_clk);
      n++;
      if (ar && arr) ar <= 0;
    end while (!rv && n < 50);
    limit(n);
    rr <= 0;
    check(rdat, e);
    check(32'(rresp), 32'(rs));
    @(posedge i_clk);
  endtask
  task automatic rnd_ops(input int k);
    repeat (k) issue(bsfe_op_e'(4'($unsigned($random(seed)) % 15)), 3'($random(seed)),
                     6'($random(seed)), 8'($random(seed)));
    ov <= 0;
    repeat (4) @(posedge i_clk);
    check(q.size(), 0);
  endtask
  // Oldest note against whatever result shows up
  always @(posedge i_clk) begin
    if (iwe) begin
      if (q.size() == 0) check(1, 0);
      else check({9'h0, 1'b1, ioa, iwd, stat}, q.pop_front());
    end else if (tk) begin
      if (q.size() == 0) check(1, 0);
      else begin
        ms = {13'h0, rwe, watchdog_restart_op, slp, rdd, stat};
        me = q.pop_front();
        check(ms & 32'h0004ff00, me & 32'h0004ff00);
        check(ms & 32'h000300ff, me & 32'h000300ff);
      end
    end
    tk <= ov && rdy && !(op inside {OP_IO_BIT_SET_OP, OP_IO_BIT_CLEAR_OP});
  end
  initial begin
    for (int i = 0; i < 64; i++) iom[i] = 8'(i * 37 + 5);
    repeat (10) @(posedge i_clk);
    i_rst <= 0;
    @(posedge i_clk);
    for (int i = 0; i < 16; i++) issue(i < 8 ? OP_FLAG_SET_BY_INDEX_OP : OP_FLAG_CLEAR_BY_INDEX_OP,
                                       3'(i), 6'h0, 8'h0);
    rnd_ops(0);
    $display("test flags done");
    rnd_ops(150);
    $display("test random ops done");
    axw(ADDR_STATUS, 32'h5a, 4'h1);
    sr = 8'h5a;
    axw(ADDR_STATUS, 32'hff, 4'h0);
    axr(ADDR_STATUS, 32'(sr));
    axw(ADDR_RESULT, 32'h3c, 4'h1);
    axr(ADDR_RESULT, 32'(lrd));
    axw(ADDR_CTRL, 32'h2, 4'hf);
    check(32'(smode), 32'h2);
    axr(ADDR_OPCOUNT, 32'(cnt[15:0]));
    axw(4'h2, 32'hff, 4'hf, RESP_SLVERR);
    axr(ADDR_STATUS, 32'(sr));
    axr(4'h2, 32'h0, RESP_SLVERR);
    $display("test registers done");
    rnd_ops(60);
    $display("test random after write done");
    test_done;
  end
endmodule
